// [ecl_error_lamps.v]
// Error code lamp indicator: latches, holds and flashes error numbers
`timescale 1ns/1ps
`include "ecl_consts.vh"
module ecl_error_lamps #(
  parameter TICK_DIV = `ECL_TICK_DIV,
  parameter [23:0] WARN_TICKS = `ECL_WARN_TICKS,
  parameter [9:0] SYS_HALF = `ECL_SYS_HALF_MS,
  parameter [9:0] PROT_HALF = `ECL_PROT_HALF_MS
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_sys_err_valid,
  input wire [3:0] i_sys_err_code,
  input wire i_prot_err_valid,
  input wire [3:0] i_prot_err_code,
  input wire [23:0] i_prot_hold_ticks,
  input wire [1:0] i_mode,
  input wire i_clear,
  output reg o_state_red,
  output reg o_error_weight_eight_lamp,
  output reg o_error_weight_four_lamp,
  output reg o_error_weight_two_lamp,
  output reg o_error_weight_one_lamp,
  output reg o_code_valid,
  output reg o_serious_halt
);
  // System code acceptance
  function sys_ok;
    input [3:0] c;
    begin
      case (c)
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE: sys_ok = 1'b1;
        default: sys_ok = 1'b0;
      endcase
    end
  endfunction

  // Protocol code acceptance
  function prot_ok;
    input [3:0] c;
    begin
      case (c)
        4'h3, 4'h5, 4'h9, 4'hB, 4'hC, 4'hE, 4'hF: prot_ok = 1'b1;
        default: prot_ok = 1'b0;
      endcase
    end
  endfunction

  // Serious codes latch until reset
  function is_serious;
    input [3:0] c;
    begin
      is_serious = (c <= `ECL_SERIOUS_MAX);
    end
  endfunction

  localparam SH_IDLE = 2'h0;
  localparam SH_SERIOUS = 2'h1;
  localparam SH_WARN = 2'h2;
  localparam SH_PROT = 2'h3;

  wire tick;
  reg [1:0] state_q;
  reg [3:0] code_q;
  reg [23:0] hold_q;
  reg [9:0] flash_cnt_q;
  reg flash_q;
  reg [1:0] mode_s1_q;
  reg [1:0] mode_q;
  reg sys_v_s1_q;
  reg sys_v_q;
  reg prot_v_s1_q;
  reg prot_v_q;
  reg [3:0] sys_c_s1_q;
  reg [3:0] sys_c_q;
  reg [3:0] prot_c_s1_q;
  reg [3:0] prot_c_q;
  reg clr_s1_q;
  reg clr_q;
  // Hold setting is static and crosses as a plain word
  reg [23:0] phold_s1_q;
  reg [23:0] phold_q;
  reg sys_v_d_q;
  reg [3:0] sys_c_d_q;
  reg prot_v_d_q;
  reg [3:0] prot_c_d_q;

  ecl_tick #(
    .DIV(TICK_DIV),
    .W(`ECL_TICK_CNT_W)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .o_tick(tick)
  );

  // Two-stage input synchronisers
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode_s1_q <= 2'h0;
      mode_q <= 2'h0;
      sys_v_s1_q <= 1'b0;
      sys_v_q <= 1'b0;
      prot_v_s1_q <= 1'b0;
      prot_v_q <= 1'b0;
      sys_c_s1_q <= 4'h0;
      sys_c_q <= 4'h0;
      prot_c_s1_q <= 4'h0;
      prot_c_q <= 4'h0;
      clr_s1_q <= 1'b0;
      clr_q <= 1'b0;
      phold_s1_q <= 24'h000000;
      phold_q <= 24'h000000;
    end
    else
    begin
      mode_s1_q <= i_mode;
      mode_q <= mode_s1_q;
      sys_v_s1_q <= i_sys_err_valid;
      sys_v_q <= sys_v_s1_q;
      prot_v_s1_q <= i_prot_err_valid;
      prot_v_q <= prot_v_s1_q;
      sys_c_s1_q <= i_sys_err_code;
      sys_c_q <= sys_c_s1_q;
      prot_c_s1_q <= i_prot_err_code;
      prot_c_q <= prot_c_s1_q;
      clr_s1_q <= i_clear;
      clr_q <= clr_s1_q;
      phold_s1_q <= i_prot_hold_ticks;
      phold_q <= phold_s1_q;
    end
  end

  // Third stage holds the previous code for the agreement test
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sys_v_d_q <= 1'b0;
      sys_c_d_q <= 4'h0;
      prot_v_d_q <= 1'b0;
      prot_c_d_q <= 4'h0;
    end
    else
    begin
      sys_v_d_q <= sys_v_q;
      sys_c_d_q <= sys_c_q;
      prot_v_d_q <= prot_v_q;
      prot_c_d_q <= prot_c_q;
    end
  end

  // Code must agree on two samples; a word caught mid-change is dropped
  // Source keeps the code one cycle past its valid
  wire sys_steady = (sys_c_d_q == sys_c_q);
  wire prot_steady = (prot_c_d_q == prot_c_q);
  wire sys_new = sys_v_d_q && sys_steady && sys_ok(sys_c_d_q);
  wire prot_new = prot_v_d_q && prot_steady && prot_ok(prot_c_d_q);
  wire sys_serious = sys_new && is_serious(sys_c_d_q);
  wire sys_warn = sys_new && !is_serious(sys_c_d_q);
  // Zero hold setting ignores protocol errors
  wire prot_take = prot_new && (phold_q != 24'h000000);
  // Display ends on the tick that would reach zero
  wire hold_end = tick && (hold_q == 24'h000001);
  wire [9:0] half = (state_q == SH_PROT) ? PROT_HALF : SYS_HALF;
  wire showing = (state_q != SH_IDLE);

  // Error display state machine
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= SH_IDLE;
      code_q <= 4'h0;
      hold_q <= 24'h000000;
    end
    else
    begin
      case (state_q)
        SH_SERIOUS:
        begin
          state_q <= SH_SERIOUS;
        end
        SH_IDLE, SH_WARN, SH_PROT:
        begin
          if (sys_serious)
          begin
            state_q <= SH_SERIOUS;
            code_q <= sys_c_d_q;
          end
          else if (sys_warn)
          begin
            state_q <= SH_WARN;
            code_q <= sys_c_d_q;
            hold_q <= WARN_TICKS;
          end
          else if (prot_take)
          begin
            state_q <= SH_PROT;
            code_q <= prot_c_d_q;
            hold_q <= phold_q;
          end
          else if (clr_q)
          begin
            state_q <= SH_IDLE;
            code_q <= 4'h0;
            hold_q <= 24'h000000;
          end
          else if ((state_q != SH_IDLE) && hold_end)
          begin
            state_q <= SH_IDLE;
            code_q <= 4'h0;
            hold_q <= 24'h000000;
          end
          else if ((state_q != SH_IDLE) && tick)
          begin
            hold_q <= hold_q - 24'h000001;
          end
        end
        default:
        begin
          state_q <= SH_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      flash_cnt_q <= 10'h000;
      flash_q <= 1'b0;
    end
    // Phase restarts off whenever nothing is shown in normal mode
    else if (!showing && (mode_q == `ECL_MODE_NORMAL))
    begin
      flash_cnt_q <= 10'h000;
      flash_q <= 1'b0;
    end
    else if (tick)
    begin
      if (flash_cnt_q >= half - 10'h001)
      begin
        flash_cnt_q <= 10'h000;
        flash_q <= ~flash_q;
      end
      else
      begin
        flash_cnt_q <= flash_cnt_q + 10'h001;
      end
    end
  end

  wire in_cfg = (mode_q == `ECL_MODE_CONFIG) || (mode_q == `ECL_MODE_TEST);
  // Lamp word, gated by the flash phase
  wire [3:0] lamps = (showing && flash_q) ? code_q : 4'h0;

  // Registered outputs
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_state_red <= 1'b0;
      o_error_weight_eight_lamp <= 1'b0;
      o_error_weight_four_lamp <= 1'b0;
      o_error_weight_two_lamp <= 1'b0;
      o_error_weight_one_lamp <= 1'b0;
      o_code_valid <= 1'b0;
      o_serious_halt <= 1'b0;
    end
    else
    begin
      // flashing red in config or test
      if (in_cfg)
        o_state_red <= flash_q;
      else
        o_state_red <= showing;
      o_error_weight_eight_lamp <= lamps[3];
      o_error_weight_four_lamp <= lamps[2];
      o_error_weight_two_lamp <= lamps[1];
      o_error_weight_one_lamp <= lamps[0];
      o_code_valid <= showing && !in_cfg;
      o_serious_halt <= (state_q == SH_SERIOUS);
    end
  end
endmodule

// [ecl_consts.vh]
// Constants for the error code lamp indicator
`ifndef ECL_CONSTS_VH
`define ECL_CONSTS_VH
`define ECL_CLK_HZ 200000000
`define ECL_TICK_HZ 1000
`define ECL_TICK_DIV (`ECL_CLK_HZ / `ECL_TICK_HZ)
`define ECL_TICK_CNT_W 18
`define ECL_WARN_TIME_S 60
`define ECL_WARN_TICKS (`ECL_WARN_TIME_S * `ECL_TICK_HZ)
`define ECL_SYS_HALF_MS 250
`define ECL_PROT_HALF_MS 500
`define ECL_HOLD_W 24
`define ECL_SERIOUS_MAX 4'h5
`define ECL_MODE_NORMAL 2'h0
`define ECL_MODE_CONFIG 2'h1
`define ECL_MODE_TEST 2'h2
`define ECL_ST_OFF 2'h0
`define ECL_ST_RED 2'h1
`define ECL_ST_RED_FLASH 2'h2
`endif

// [ecl_tick.v]
// Prescaler producing a one-cycle tick enable from the system clock
`timescale 1ns/1ps
module ecl_tick #(
  parameter DIV = 200000,
  parameter W = 18
) (
  input wire i_clk_sys,
  input wire i_resetn,
  output reg o_tick
);
  localparam [31:0] LAST_FULL = DIV - 1;
  localparam [W-1:0] LAST = LAST_FULL[W-1:0];
  reg [W-1:0] cnt_q;
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= {W{1'b0}};
      o_tick <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= {W{1'b0}};
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule

// [ecl_lamp_watch.sv]
// Operator model reading the state lamp and the four number lamps
`timescale 1ns/1ps
module ecl_lamp_watch (
  input wire i_clk_sys,
  input wire i_red,
  input wire [3:0] i_lamps,
  output logic [3:0] o_code = 4'h0,
  output logic [7:0] o_on_len = 8'h00
);
  logic [7:0] run_q = 8'h00;
  always @(posedge i_clk_sys)
  begin
    if (i_red && i_lamps != 4'h0)
    begin
      o_code <= i_lamps;
      run_q <= run_q + 8'h01;
    end
    else
    begin
      if (run_q != 8'h00)
        o_on_len <= run_q;
      run_q <= 8'h00;
    end
  end
endmodule

// [ecl_checker.sv]
// Assertion checker for the error lamp indicator
`timescale 1ns/1ps
module ecl_checker (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_sys_err_valid,
  input wire [3:0] i_sys_err_code,
  input wire i_prot_err_valid,
  input wire [3:0] i_prot_err_code,
  input wire [1:0] i_mode,
  input wire i_clear,
  input wire o_state_red,
  input wire o_error_weight_eight_lamp,
  input wire o_error_weight_four_lamp,
  input wire o_error_weight_two_lamp,
  input wire o_error_weight_one_lamp,
  input wire o_code_valid,
  input wire o_serious_halt
);
  wire [3:0] lamps = {o_error_weight_eight_lamp, o_error_weight_four_lamp,
    o_error_weight_two_lamp, o_error_weight_one_lamp};
  wire quiet = i_mode == 2'h0 && !o_code_valid && !o_serious_halt;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  sequence s_shown;
    ##[3:5] o_code_valid && o_state_red;
  endsequence
  property p_halt;
    $rose(i_sys_err_valid) && i_sys_err_code inside {[1:5]} && quiet
      |-> s_shown ##0 o_serious_halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("serious code not latched");
  property p_stay;
    o_serious_halt |=> o_serious_halt;
  endproperty
  a_stay: assert property (p_stay)
    else $error("serious halt dropped");
  property p_warn;
    $rose(i_sys_err_valid) && i_sys_err_code inside {7, 8, 9, 10, 11, 13, 14} && quiet
      |-> s_shown;
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning not shown");
  property p_prot;
    $rose(i_prot_err_valid) && i_prot_err_code inside {3, 5, 9, 11, 12, 14, 15}
      && quiet && !i_sys_err_valid |-> s_shown;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protocol error not shown");
  property p_red;
    o_code_valid |-> o_state_red;
  endproperty
  a_red: assert property (p_red)
    else $error("code valid without red state");
  property p_cfg;
    (i_mode != 2'h0) [*4] |-> !o_code_valid;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("code valid in config or test mode");
  property p_clr;
    (i_clear && !i_sys_err_valid && !i_prot_err_valid && !o_serious_halt) [*3]
      |-> ##[0:3] !o_code_valid;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear did not drop display");
  property p_flash;
    o_code_valid && $changed(lamps) |=> ($stable(lamps) || !o_code_valid) [*6];
  endproperty
  a_flash: assert property (p_flash)
    else $error("lamps flash too fast");
endmodule

// [tb_top.sv]
// Testbench for the error lamp indicator
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sv = 1'b0;
  logic pv = 1'b0;
  logic clr = 1'b0;
  logic [3:0] sc = 4'h0;
  logic [3:0] pc = 4'h0;
  logic [1:0] mode = 2'h0;
  logic red, l8, l4, l2, l1, cv, halt;
  logic [3:0] code;
  logic [7:0] onl;
  logic [3:0] wc[7] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE};
  logic [3:0] pcs[7] = '{4'h3, 4'h5, 4'h9, 4'hB, 4'hC, 4'hE, 4'hF};
  logic [3:0] rc[4] = '{4'h0, 4'h6, 4'hC, 4'hF};
  int errors = 0;
  int checks_done = 0;
  ecl_error_lamps #(.TICK_DIV(4), .WARN_TICKS(24'h14), .SYS_HALF(10'h2),
    .PROT_HALF(10'h4)) u_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_sys_err_valid(sv),
    .i_sys_err_code(sc), .i_prot_err_valid(pv), .i_prot_err_code(pc),
    .i_prot_hold_ticks(24'h1E), .i_mode(mode), .i_clear(clr), .o_state_red(red),
    .o_error_weight_eight_lamp(l8), .o_error_weight_four_lamp(l4),
    .o_error_weight_two_lamp(l2), .o_error_weight_one_lamp(l1), .o_code_valid(cv),
    .o_serious_halt(halt));
  ecl_lamp_watch u_watch (.i_clk_sys(clk), .i_red(red), .i_lamps({l8, l4, l2, l1}),
    .o_code(code), .o_on_len(onl));
  initial forever #2.5 clk = ~clk;
  task stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %0h got %0h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task fire(input logic p, input logic [3:0] c);
    cyc(1);
    pc = c;
    sc = c;
    pv = p;
    sv = !p;
    cyc(1);
    pv = 1'b0;
    sv = 1'b0;
  endtask
  task wait_cv;
    int n;
    n = 0;
    while (cv !== 1'b1)
    begin
      cyc(1);
      n++;
      if (n > 30)
      begin
        errors++;
        stop_test;
      end
    end
  endtask
  task show(input logic p, input logic [3:0] c, input int half, input int life);
    int n;
    fire(p, c);
    wait_cv;
    n = 2 * half + 6;
    cyc(n);
    chk("code", c, code);
    chk("flash", half, onl);
    while (cv === 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("life", 1, n > life - 9 && n < life + 9);
  endtask
  task cfg(input logic [1:0] m);
    int t;
    t = 0;
    mode = m;
    cyc(6);
    fire(0, 4'hA);
    repeat (24)
    begin
      cyc(1);
      t += red;
    end
    chk("cfg", 0, cv);
    chk("blink", 1, t > 0 && t < 24);
    mode = 2'h0;
    cyc(6);
    wait_cv;
    clr = 1'b1;
    cyc(6);
    chk("clr", 0, cv);
    clr = 1'b0;
  endtask
  task serious(input logic [3:0] c);
    rstn = 1'b0;
    cyc(6);
    rstn = 1'b1;
    cyc(2);
    fire(0, c);
    wait_cv;
    fire(0, 4'h9);
    clr = 1'b1;
    cyc(100);
    clr = 1'b0;
    chk("halt", 1, halt);
    chk("kept", c, code);
    chk("shown", 1, cv);
  endtask
  initial
  begin
    cyc(6);
    rstn = 1'b1;
    cyc(2);
    foreach (wc[i]) show(0, wc[i], 8, 80);
    foreach (pcs[i]) show(1, pcs[i], 16, 120);
    foreach (rc[i])
    begin
      fire(0, rc[i]);
      cyc(10);
      chk("resv", 0, cv);
    end
    cfg(2'h1);
    cfg(2'h2);
    for (int c = 1; c < 6; c++) serious(c[3:0]);
    rstn = 1'b0;
    cyc(2);
    chk("rst", 0, halt);
    stop_test;
  end
endmodule
bind ecl_error_lamps ecl_checker u_chk (.*);
